// >>> pkg/bpd_pkg.sv
// constants and types for the bridge dead-band and shutdown stage
`default_nettype none
package bpd_pkg;
  // ****************************************
  // register map (plain port, 3-bit address)
  // ****************************************
  localparam logic [2:0] ADDR_DB   = 3'h0;
  localparam logic [2:0] ADDR_SD   = 3'h1;
  localparam logic [2:0] ADDR_MAIN = 3'h2;
  localparam logic [2:0] ADDR_PER  = 3'h3;
  localparam logic [2:0] ADDR_DUTY = 3'h4;
  localparam logic [2:0] ADDR_STAT = 3'h5;
  localparam logic [2:0] ADDR_TMR  = 3'h6;
  localparam logic [7:0] REG_RST   = 8'h00;
  // ****************************************
  // field positions
  // ****************************************
  localparam int DB_RESTART_BIT  = 7;
  localparam int DB_CNT_MSB      = 6;
  localparam int SD_FLAG_BIT     = 7;
  localparam int SD_SRC_MSB      = 6;
  localparam int SD_SRC_LSB      = 4;
  localparam int SD_AC_MSB       = 3;
  localparam int SD_AC_LSB       = 2;
  localparam int SD_BD_MSB       = 1;
  localparam int SD_BD_LSB       = 0;
  localparam int MAIN_CFG_MSB    = 7;
  localparam int MAIN_CFG_LSB    = 6;
  localparam int MAIN_TMR_ON_BIT = 2;
  localparam int MAIN_POL_AC_BIT = 1;
  localparam int MAIN_POL_BD_BIT = 0;
  localparam int STAT_TFLAG_BIT  = 0;
  localparam int STAT_COND_BIT   = 1;
  // ****************************************
  // codes and timing
  // ****************************************
  localparam logic [1:0] SS_HIGH    = 2'h1;
  localparam int         SS_TRI_BIT = 1;
  // one instruction cycle is four oscillator (clk) periods
  localparam int         TCY_OSC    = 4;
  localparam logic [1:0] TCY_LAST   = 2'(TCY_OSC - 1);
  localparam logic [6:0] DB_MAX     = 7'h7F;
  typedef enum logic [1:0] {
    BPD_CFG_SINGLE,
    BPD_CFG_HALF,
    BPD_CFG_FWD,
    BPD_CFG_REV
  } bpd_cfg_t;
endpackage : bpd_pkg
`default_nettype wire

// >>> rtl/bpd_bridge_pwm.sv
// bridge pwm stage with dead-band delay and auto-shutdown
`timescale 1ns/100ps
`default_nettype none
module bpd_bridge_pwm (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  input  wire logic       fault_in_n,
  input  wire logic       cmp1_out,
  input  wire logic       cmp2_out,
  output logic            bridge_out_a,
  output logic            bridge_out_b,
  output logic            bridge_out_c,
  output logic            bridge_out_d,
  output logic            bridge_oe_a,
  output logic            bridge_oe_b,
  output logic            bridge_oe_c,
  output logic            bridge_oe_d
);

  // ****************************************
  // functions
  // ****************************************
  // next dead-band count: cleared while the raw drive is inactive
  function automatic logic [6:0] db_step(
    input logic       raw,
    input logic [6:0] cnt,
    input logic       tick
  );
    logic [6:0] r;
    r = cnt;
    if (!raw) begin
      r = 7'h00;
    end else if (tick && cnt != bpd_pkg::DB_MAX) begin
      r = cnt + 7'h01;
    end
    return r;
  endfunction : db_step

  function automatic logic ss_level(input logic [1:0] s);
    return s == bpd_pkg::SS_HIGH;
  endfunction : ss_level

  function automatic logic ss_drive(input logic [1:0] s);
    return !s[bpd_pkg::SS_TRI_BIT];
  endfunction : ss_drive

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] db_q;
  logic [7:0] sd_q;
  logic [7:0] main_q;
  logic [7:0] per_q;
  logic [7:0] duty_q;
  logic [7:0] duty_buf_q;
  logic [7:0] timer_q;
  logic [1:0] div_q;
  logic       tflag_q;
  logic       flag_q;
  logic       flag_d;
  logic       held_q;
  logic       pwm_q;
  logic [6:0] cnt_a_q;
  logic [6:0] cnt_b_q;
  logic [3:0] act_q;
  logic [7:0] rdata_q;

  // ****************************************
  // decode
  // ****************************************
  wire        wr_db    = wr_en && addr == bpd_pkg::ADDR_DB;
  wire        wr_sd    = wr_en && addr == bpd_pkg::ADDR_SD;
  wire        wr_main  = wr_en && addr == bpd_pkg::ADDR_MAIN;
  wire        wr_per   = wr_en && addr == bpd_pkg::ADDR_PER;
  wire        wr_duty  = wr_en && addr == bpd_pkg::ADDR_DUTY;
  wire        wr_stat  = wr_en && addr == bpd_pkg::ADDR_STAT;
  wire        restart  = db_q[bpd_pkg::DB_RESTART_BIT];
  wire [6:0]  db_cnt   = db_q[bpd_pkg::DB_CNT_MSB:0];
  wire [2:0]  src_sel  = sd_q[bpd_pkg::SD_SRC_MSB:bpd_pkg::SD_SRC_LSB];
  wire [1:0]  ss_ac    = sd_q[bpd_pkg::SD_AC_MSB:bpd_pkg::SD_AC_LSB];
  wire [1:0]  ss_bd    = sd_q[bpd_pkg::SD_BD_MSB:bpd_pkg::SD_BD_LSB];
  wire        tmr_on   = main_q[bpd_pkg::MAIN_TMR_ON_BIT];
  wire        pol_ac   = main_q[bpd_pkg::MAIN_POL_AC_BIT];
  wire        pol_bd   = main_q[bpd_pkg::MAIN_POL_BD_BIT];
  wire [1:0]  cfg_bits = main_q[bpd_pkg::MAIN_CFG_MSB:bpd_pkg::MAIN_CFG_LSB];
  bpd_pkg::bpd_cfg_t cfg;
  assign cfg = bpd_pkg::bpd_cfg_t'(cfg_bits);
  wire        half     = cfg == bpd_pkg::BPD_CFG_HALF;

  // ****************************************
  // shutdown sources
  // ****************************************
  // comparators stay level: they block clearing for as long as they hold
  wire        src_flt  = src_sel[2] && !fault_in_n;
  wire        src_c1   = src_sel[0] && cmp1_out;
  wire        src_c2   = src_sel[1] && cmp2_out;
  wire        cond     = src_flt || src_c1 || src_c2;

  // ****************************************
  // instruction-cycle divider and period timer
  // ****************************************
  wire        tick     = div_q == bpd_pkg::TCY_LAST;
  wire        tstep    = tick && tmr_on;
  wire        at_limit = timer_q == per_q;
  wire        pstart   = tstep && at_limit;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      timer_q    <= bpd_pkg::REG_RST;
      duty_buf_q <= bpd_pkg::REG_RST;
    end else if (pstart) begin
      timer_q    <= bpd_pkg::REG_RST;
      duty_buf_q <= duty_q;
    end else if (tstep) begin
      timer_q    <= timer_q + 8'h01;
    end
  end

  // every rollover is a new period; the first marks the second period
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tflag_q <= 1'b0;
    end else if (pstart) begin
      tflag_q <= 1'b1;
    end else if (wr_stat) begin
      tflag_q <= wdata[bpd_pkg::STAT_TFLAG_BIT];
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      db_q   <= bpd_pkg::REG_RST;
      main_q <= bpd_pkg::REG_RST;
      per_q  <= bpd_pkg::REG_RST;
      duty_q <= bpd_pkg::REG_RST;
    end else begin
      if (wr_db) begin
        db_q <= wdata;
      end
      if (wr_main) begin
        main_q <= wdata;
      end
      if (wr_per) begin
        per_q <= wdata;
      end
      if (wr_duty) begin
        duty_q <= wdata;
      end
    end
  end

  // flag bit lives in flag_q; the rest of the byte is plain storage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sd_q <= bpd_pkg::REG_RST;
    end else if (wr_sd) begin
      sd_q <= wdata;
    end
  end

  // ****************************************
  // shutdown event flag
  // ****************************************
  // a live cause wins over any clear, software or automatic
  always_comb begin
    flag_d = flag_q;
    if (wr_sd) begin
      flag_d = wdata[bpd_pkg::SD_FLAG_BIT];
    end else if (restart && !cond) begin
      flag_d = 1'b0;
    end
    if (cond) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // keeps the outputs parked until a period starts with the flag clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      held_q <= 1'b0;
    end else if (flag_q) begin
      held_q <= 1'b1;
    end else if (pstart) begin
      held_q <= 1'b0;
    end
  end

  // ****************************************
  // pwm and dead-band
  // ****************************************
  wire        raw_a = pwm_q;
  wire        raw_b = tmr_on && !pwm_q;
  wire        dly_a = raw_a && cnt_a_q >= db_cnt;
  wire        dly_b = raw_b && cnt_b_q >= db_cnt;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pwm_q   <= 1'b0;
      cnt_a_q <= 7'h00;
      cnt_b_q <= 7'h00;
    end else begin
      if (tick) begin
        pwm_q <= tmr_on && timer_q < duty_buf_q;
      end
      cnt_a_q <= db_step(raw_a, cnt_a_q, tick);
      cnt_b_q <= db_step(raw_b, cnt_b_q, tick);
    end
  end

  // active levels per pin, order {d, c, b, a}; only half mode sees the dead-band
  wire [3:0]  act_d = (cfg == bpd_pkg::BPD_CFG_SINGLE) ? {3'h0, raw_a} :
                      (cfg == bpd_pkg::BPD_CFG_HALF)   ? {2'h0, dly_b, dly_a} :
                      (cfg == bpd_pkg::BPD_CFG_FWD)    ? {raw_a, 2'h0, tmr_on} :
                                                         {1'b0, tmr_on, raw_a, 1'b0};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      act_q <= 4'h0;
    end else begin
      act_q <= act_d;
    end
  end

  // ****************************************
  // pins
  // ****************************************
  // the shutdown path bypasses every flop so a fault acts at once
  wire shut = cond || flag_q || held_q;

  assign bridge_out_a = shut ? ss_level(ss_ac) : act_q[0] ^ pol_ac;
  assign bridge_out_c = shut ? ss_level(ss_ac) : act_q[2] ^ pol_ac;
  assign bridge_out_b = shut ? ss_level(ss_bd) : act_q[1] ^ pol_bd;
  assign bridge_out_d = shut ? ss_level(ss_bd) : act_q[3] ^ pol_bd;
  assign bridge_oe_a  = !shut || ss_drive(ss_ac);
  assign bridge_oe_c  = !shut || ss_drive(ss_ac);
  assign bridge_oe_b  = !shut || ss_drive(ss_bd);
  assign bridge_oe_d  = !shut || ss_drive(ss_bd);

  // ****************************************
  // read port
  // ****************************************
  // unmapped addresses read as zero
  wire [7:0]  rd_mux = (addr == bpd_pkg::ADDR_DB)   ? db_q :
                       (addr == bpd_pkg::ADDR_SD)   ? {flag_q, sd_q[bpd_pkg::SD_SRC_MSB:0]} :
                       (addr == bpd_pkg::ADDR_MAIN) ? main_q :
                       (addr == bpd_pkg::ADDR_PER)  ? per_q :
                       (addr == bpd_pkg::ADDR_DUTY) ? duty_q :
                       (addr == bpd_pkg::ADDR_STAT) ? {6'h00, cond, tflag_q} :
                       (addr == bpd_pkg::ADDR_TMR)  ? timer_q :
                                                      8'h00;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_en ? rd_mux : 8'h00;
    end
  end
  assign rdata = rdata_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_flag_set;
    cond |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("cause did not set the flag");

  property p_pin_now;
    cond |-> bridge_out_a == ss_level(ss_ac) && bridge_oe_b == ss_drive(ss_bd);
  endproperty
  a_pin_now: assert property (p_pin_now)
    else $error("pins not in shutdown state with cause live");

  property p_auto_clr;
    restart && flag_q && !cond && !wr_sd |=> !flag_q;
  endproperty
  a_auto_clr: assert property (p_auto_clr)
    else $error("auto restart did not clear the flag");

  property p_manual_hold;
    !restart && flag_q && !wr_sd |=> flag_q;
  endproperty
  a_manual_hold: assert property (p_manual_hold)
    else $error("flag cleared without software");

  property p_wr_blocked;
    cond && wr_sd && !wdata[bpd_pkg::SD_FLAG_BIT] |=> flag_q;
  endproperty
  a_wr_blocked: assert property (p_wr_blocked)
    else $error("flag cleared while cause active");

  property p_sw_force;
    wr_sd && wdata[bpd_pkg::SD_FLAG_BIT] |=> ##1 shut && !bridge_oe_a == !ss_drive(ss_ac);
  endproperty
  a_sw_force: assert property (p_sw_force)
    else $error("software force did not shut outputs");

  property p_period_hold;
    pstart && flag_q |=> held_q;
  endproperty
  a_period_hold: assert property (p_period_hold)
    else $error("flag at period start did not hold outputs");

  property p_resume_edge;
    $fell(held_q) |-> $past(pstart);
  endproperty
  a_resume_edge: assert property (p_resume_edge)
    else $error("outputs resumed in mid period");

  property p_tflag;
    pstart |=> tflag_q && timer_q == 8'h00;
  endproperty
  a_tflag: assert property (p_tflag)
    else $error("rollover missed flag or clear");

  property p_db_fall;
    half && $fell(pwm_q) ##1 half && !shut |-> bridge_out_a == pol_ac;
  endproperty
  a_db_fall: assert property (p_db_fall)
    else $error("falling edge of a was delayed");

  property p_db_rise;
    half && $rose(pwm_q) && db_cnt != 7'h00 |=> !act_q[0];
  endproperty
  a_db_rise: assert property (p_db_rise)
    else $error("rising edge of a not delayed");

  c_shutdown:  cover property (cond ##1 flag_q);
  c_restart:   cover property (restart && flag_q ##1 !flag_q);
  c_resume:    cover property ($fell(held_q));
  c_deadband:  cover property (half && db_cnt != 7'h00 && $rose(act_q[0]));

endmodule : bpd_bridge_pwm
`default_nettype wire

// >>> bench/bpd_switch_model.sv
// far-side model: bridge switch drivers with pull-downs on every pin
`timescale 1ns/100ps
`default_nettype none
module bpd_switch_model (
  input  wire logic [3:0] out,
  input  wire logic [3:0] oe,
  input  wire logic       pins_en,
  output logic      [3:0] pin
);
  // ****************************************
  // pin resolution
  // ****************************************
  // a pin still held as input, or released by the stage, falls to its pull-down,
  // so the switch stays off; the pull-down keeps the level known, never the last value
  assign pin = out & oe & {4{pins_en}};
endmodule : bpd_switch_model
`default_nettype wire

// >>> bench/bpd_bridge_pwm_bench.sv
// testbench for the bridge dead-band and shutdown stage
`timescale 1ns/100ps
`default_nettype none
module bpd_bridge_pwm_bench;
  logic       clk;
  logic       reset_n;
  logic       wr_en;
  logic       rd_en;
  logic       fault_in_n;
  logic       cmp1_out;
  logic       cmp2_out;
  logic       pins_en;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic [7:0] sdv;
  logic       hit;
  logic [3:0] o;
  logic [3:0] oe;
  logic [3:0] pin;
  logic [7:0] cnt [4];
  // high cycles per 64-clock period, pins a..d, for single, half, fwd, rev
  logic [7:0] exp_tab [4][4] = '{'{8'h18, 8'h00, 8'h00, 8'h00}, '{8'h10, 8'h20, 8'h00, 8'h00},
                                 '{8'h40, 8'h00, 8'h00, 8'h18}, '{8'h00, 8'h18, 8'h40, 8'h00}};
  int         n_fail;
  int         checks;
  int         cyc;
  int         k;

  bpd_bridge_pwm i_bpd_bridge_pwm (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .fault_in_n(fault_in_n), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
    .bridge_out_a(o[0]), .bridge_out_b(o[1]), .bridge_out_c(o[2]), .bridge_out_d(o[3]),
    .bridge_oe_a(oe[0]), .bridge_oe_b(oe[1]), .bridge_oe_c(oe[2]), .bridge_oe_d(oe[3])
  );

  bpd_switch_model i_bpd_switch_model (.out(o), .oe(oe), .pins_en(pins_en), .pin(pin));

  // ****************************************
  // clock, timeout and report
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task final_report();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // whole run needs about 5200 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task rd(input logic [2:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    rv = rdata;
  endtask : rd

  task rdc(input logic [2:0] a, input logic [7:0] exp);
    rd(a);
    chk8(rv, exp);
  endtask : rdc

  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task measure();
    cnt = '{default: 8'h00};
    repeat (64) begin
      @(negedge clk);
      for (int i = 0; i < 4; i++) begin
        cnt[i] = cnt[i] + 8'(pin[i]);
      end
    end
  endtask : measure

  // src 0 comparator one, 1 comparator two, 2 fault input (active low)
  task set_cause(input int src, input logic v);
    @(posedge clk);
    if (src == 0) cmp1_out <= v;
    if (src == 1) cmp2_out <= v;
    if (src == 2) fault_in_n <= ~v;
  endtask : set_cause

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    fault_in_n = 1'b1;
    cmp1_out = 1'b0;
    cmp2_out = 1'b0;
    pins_en = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rdc(bpd_pkg::ADDR_DB, 8'h00);
    rdc(bpd_pkg::ADDR_SD, 8'h00);
    wr(3'h7, 8'hFF);
    rdc(3'h7, 8'h00);
    // setup order with pins held as inputs until a full cycle has run
    wr(bpd_pkg::ADDR_PER, 8'h0F);
    wr(bpd_pkg::ADDR_SD, 8'h84);
    rdc(bpd_pkg::ADDR_SD, 8'h84);
    wr(bpd_pkg::ADDR_DUTY, 8'h06);
    wr(bpd_pkg::ADDR_DB, 8'h02);
    wr(bpd_pkg::ADDR_MAIN, 8'h44);
    rd(bpd_pkg::ADDR_STAT);
    chk1(rv[0], 1'b0);
    k = 0;
    while (rv[0] !== 1'b1 && k < 100) begin
      rd(bpd_pkg::ADDR_STAT);
      k++;
    end
    chk1(rv[0], 1'b1);
    pins_en <= 1'b1;
    wr(bpd_pkg::ADDR_SD, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(bpd_pkg::ADDR_MAIN, {2'(c), 6'h04});
      idle(130);
      measure();
      for (int i = 0; i < 4; i++) chk8(cnt[i], exp_tab[c][i]);
    end
    wr(bpd_pkg::ADDR_MAIN, 8'h44);
    wr(bpd_pkg::ADDR_DB, 8'h07);
    idle(130);
    measure();
    chk8(cnt[0], 8'h00);
    chk8(cnt[1], 8'h0C);
    // duty 0 in half mode parks a low and b high, opposite to the shutdown levels
    wr(bpd_pkg::ADDR_DB, 8'h00);
    wr(bpd_pkg::ADDR_DUTY, 8'h00);
    idle(130);
    for (int s = 1; s < 8; s++) begin
      for (int src = 0; src < 3; src++) begin
        hit = s[src];
        sdv = {1'b0, 3'(s), 4'h4};
        wr(bpd_pkg::ADDR_SD, sdv);
        set_cause(src, 1'b1);
        @(negedge clk);
        chk1(pin[0], hit);
        chk1(pin[1], ~hit);
        rd(bpd_pkg::ADDR_STAT);
        chk1(rv[1], hit);
        wr(bpd_pkg::ADDR_SD, sdv);
        rdc(bpd_pkg::ADDR_SD, {hit, sdv[6:0]});
        set_cause(src, 1'b0);
        idle(2);
        rdc(bpd_pkg::ADDR_SD, {hit, sdv[6:0]});
        wr(bpd_pkg::ADDR_SD, sdv);
        rdc(bpd_pkg::ADDR_SD, sdv);
        idle(130);
        chk1(pin[0], 1'b0);
      end
    end
    for (int st = 0; st < 4; st++) begin
      wr(bpd_pkg::ADDR_SD, {4'h8, 2'(st), 2'(st)});
      @(negedge clk);
      for (int i = 0; i < 4; i++) begin
        chk1(pin[i], st == 1);
        chk1(oe[i], st < 2);
      end
      wr(bpd_pkg::ADDR_SD, 8'h00);
      idle(130);
    end
    wr(bpd_pkg::ADDR_DB, 8'h80);
    wr(bpd_pkg::ADDR_SD, 8'h44);
    set_cause(2, 1'b1);
    idle(3);
    rdc(bpd_pkg::ADDR_SD, 8'hC4);
    set_cause(2, 1'b0);
    idle(3);
    rdc(bpd_pkg::ADDR_SD, 8'h44);
    k = 0;
    while (pin[0] !== 1'b0 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk1(pin[0], 1'b0);
    rd(bpd_pkg::ADDR_TMR);
    chk1(rv > 8'h01, 1'b0);
    wr(bpd_pkg::ADDR_DB, 8'h00);
    // polarity only changes while the pins are held as inputs
    pins_en <= 1'b0;
    wr(bpd_pkg::ADDR_MAIN, 8'h47);
    idle(130);
    pins_en <= 1'b1;
    @(negedge clk);
    chk1(pin[0], 1'b1);
    chk1(pin[1], 1'b0);
    // a second reset in mid-run must clear both control registers again
    wr(bpd_pkg::ADDR_DB, 8'hFF);
    wr(bpd_pkg::ADDR_SD, 8'h3F);
    @(posedge clk);
    reset_n <= 1'b0;
    idle(2);
    reset_n <= 1'b1;
    rdc(bpd_pkg::ADDR_DB, 8'h00);
    rdc(bpd_pkg::ADDR_SD, 8'h00);
    final_report();
  end
endmodule : bpd_bridge_pwm_bench
`default_nettype wire
